// ==== core/aisr_port.sv ====
// i2c slave result and configuration port of a delta-sigma converter
//
// What this block does
// - data line only pulled low or released
// - runs standard and fast mode bit rates
// - slave only; clock input, data two-way
// - start is data fall, clock high
// - stop is data rise, clock high
// - repeated start handled like start
// - eight data bits then one acknowledge
// - data changes only while clock low
// - address then direction, one means read
// - selected only on own pin address
// - nack while converting, ack when done
// - holds 32-bit result, 16-bit configuration
// - sleeps after conversion until addressed
// - four bytes read starts new conversion
// - result bits change on clock fall
// - bit 31 is sign, high when nonnegative
// - bit 30 flags range with sign
// - 24 code bits, then six sub bits
// - stop after write or short read converts
// - reset conversion uses default setup
// - preamble 000/100/101; only 101 loads channel
// - result held unchanged while asleep
`timescale 1ns/10ps
`default_nettype none

module aisr_port
    import aisr_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [ADDR_W-1:0] dev_addr,
    input wire aisr_result_s res_in,
    input wire logic res_in_valid,
    output logic res_in_ready,
    output logic conv_start,
    output logic converting,
    output logic [CFG_W-1:0] cfg_o,
    output logic bus_busy
);
    // all port state lives in one record, rebuilt every cycle
    aisr_port_s state_q;
    aisr_port_s state_d;

    // synchronised pins and the converter word leaving the fifo
    aisr_pins_s pins_raw;
    aisr_pins_s pins;
    aisr_result_s res_word;
    logic res_valid;

    // handshake and one-cycle strobes
    logic fifo_pop;
    logic start_conv;

    // bus events decoded from the synchronised lines
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic addr_match;

    // every pin passes two flops; 200 MHz sampling leaves wide margin at 400k
    assign pins_raw = '{dev_addr: dev_addr, scl: scl_i, sda: sda_i};

    aisr_sync #(
        .WIDTH($bits(aisr_pins_s)),
        .RESET_VAL(PINS_IDLE)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_i(pins_raw),
        .sync_o(pins)
    );

    // finished conversions queue here; the port drains only while converting
    aisr_fifo #(
        .WIDTH($bits(aisr_result_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_data(res_in),
        .in_valid(res_in_valid),
        .in_ready(res_in_ready),
        .out_data(res_word),
        .out_valid(res_valid),
        .out_ready(fifo_pop)
    );

    // clock edges and bus conditions seen on the synchronised lines
    assign scl_rise = pins.scl && !state_q.scl_prev;
    assign scl_fall = !pins.scl && state_q.scl_prev;
    assign start_seen = pins.scl && state_q.scl_prev && state_q.sda_prev && !pins.sda;
    assign stop_seen = pins.scl && state_q.scl_prev && !state_q.sda_prev && pins.sda;

    // the direction bit is the last one in, the address sits above it
    assign addr_match = (state_q.shin[BYTE_W-1:1] == pins.dev_addr);

    // next state: start and stop take priority over any bit handling
    always_comb begin
        state_d = state_q;
        fifo_pop = 1'b0;
        start_conv = 1'b0;
        state_d.conv_start = 1'b0;

        // last line levels; edges are judged against these
        state_d.scl_prev = pins.scl;
        state_d.sda_prev = pins.sda;

        // converter hands back a word: keep it and go to sleep
        if (state_q.busy && res_valid) begin
            fifo_pop = 1'b1;
            state_d.result = res_word;
            state_d.busy = 1'b0;
        end

        if (start_seen) begin
            // a repeated start lands here too and keeps the bus busy
            state_d.bus_busy = 1'b1;
            state_d.st = AISR_ADDR;
            state_d.cnt = '0;
            state_d.sda_oe = 1'b0;
        end else if (stop_seen) begin
            state_d.bus_busy = 1'b0;
            state_d.st = AISR_IDLE;
            state_d.sda_oe = 1'b0;
            // write or short read since the last stop triggers a conversion
            if ((state_q.wvalid || state_q.rd_active) && !state_q.busy) begin
                start_conv = 1'b1;
            end
            state_d.wvalid = 1'b0;
            state_d.rd_active = 1'b0;
        end else begin
            unique case (state_q.st)
                // released: bits after a nack are ignored until start or stop
                AISR_IDLE: begin
                    state_d.sda_oe = 1'b0;
                end

                // seven address bits and the direction bit
                AISR_ADDR: begin
                    if (scl_rise) begin
                        state_d.shin = {state_q.shin[BYTE_W-2:0], pins.sda};
                        state_d.cnt = state_q.cnt + 1'b1;
                    end else if (scl_fall && state_q.cnt == BYTE_LAST) begin
                        state_d.cnt = '0;
                        if (addr_match && !state_q.busy) begin
                            state_d.sda_oe = 1'b1;
                            state_d.rw = state_q.shin[0];
                            state_d.st = AISR_ADDR_ACK;
                            state_d.nbytes = '0;
                            state_d.wbytes = '0;
                            // a read copies the held result into the shifter
                            if (state_q.shin[0] == RW_READ) begin
                                state_d.rd_active = 1'b1;
                                state_d.shout = state_q.result;
                            end else begin
                                state_d.wvalid = 1'b1;
                            end
                        end else begin
                            // busy or not ours: line stays released
                            state_d.st = AISR_IDLE;
                        end
                    end
                end

                // end of our acknowledge: start sending or receiving
                AISR_ADDR_ACK: begin
                    if (scl_fall) begin
                        state_d.cnt = '0;
                        // a read puts the sign bit out at once, a write waits
                        if (state_q.rw == RW_READ) begin
                            state_d.st = AISR_READ;
                            state_d.sda_oe = !state_q.shout[RESULT_W-1];
                            state_d.shout = {state_q.shout[RESULT_W-2:0], 1'b0};
                        end else begin
                            state_d.st = AISR_WRITE;
                            state_d.sda_oe = 1'b0;
                        end
                    end
                end

                // result bits leave on the falling clock, sign first
                AISR_READ: begin
                    if (scl_rise) begin
                        state_d.cnt = state_q.cnt + 1'b1;
                    end else if (scl_fall) begin
                        if (state_q.cnt == BYTE_LAST) begin
                            // hand the line to the master for its acknowledge
                            state_d.sda_oe = 1'b0;
                            state_d.st = AISR_READ_ACK;
                            state_d.nbytes = state_q.nbytes + 1'b1;
                            // the fourth byte out converts, whatever the master acks
                            if (state_q.nbytes + 1'b1 == RESULT_BYTES && !state_q.busy) begin
                                start_conv = 1'b1;
                                state_d.rd_active = 1'b0;
                            end
                        end else begin
                            state_d.sda_oe = !state_q.shout[RESULT_W-1];
                            state_d.shout = {state_q.shout[RESULT_W-2:0], 1'b0};
                        end
                    end
                end

                // master acknowledge decides whether another byte follows
                AISR_READ_ACK: begin
                    if (scl_rise) begin
                        state_d.mack = !pins.sda;
                    end else if (scl_fall) begin
                        state_d.cnt = '0;
                        // low on the ninth clock asks for more, up to four bytes
                        if (state_q.mack && state_q.nbytes != RESULT_BYTES) begin
                            state_d.st = AISR_READ;
                            state_d.sda_oe = !state_q.shout[RESULT_W-1];
                            state_d.shout = {state_q.shout[RESULT_W-2:0], 1'b0};
                        end else begin
                            // last byte out or master done: released, wait for stop
                            state_d.st = AISR_IDLE;
                        end
                    end
                end

                // configuration bytes; a third byte is refused
                AISR_WRITE: begin
                    if (scl_rise) begin
                        state_d.shin = {state_q.shin[BYTE_W-2:0], pins.sda};
                        state_d.cnt = state_q.cnt + 1'b1;
                    end else if (scl_fall && state_q.cnt == BYTE_LAST) begin
                        state_d.cnt = '0;
                        // a third byte gets no acknowledge and is dropped
                        if (state_q.wbytes < CFG_BYTES) begin
                            state_d.sda_oe = 1'b1;
                            state_d.st = AISR_WRITE_ACK;
                            state_d.wbytes = state_q.wbytes + 1'b1;
                            // first byte carries the preamble, the second the modes
                            if (state_q.wbytes == '0) begin
                                state_d.pre = state_q.shin[BYTE_W-1:BYTE_W-PRE_W];
                                // only the load pattern replaces the channel choice
                                if (state_q.shin[BYTE_W-1:BYTE_W-PRE_W] == PRE_LOAD) begin
                                    state_d.cfg[CFG_W-1:BYTE_W] = state_q.shin;
                                end
                            end else if (state_q.pre == PRE_LOAD ||
                                         state_q.pre == PRE_KEEP_B) begin
                                state_d.cfg[BYTE_W-1:0] = state_q.shin;
                            end
                        end else begin
                            state_d.st = AISR_IDLE;
                        end
                    end
                end

                // our acknowledge stands until the ninth clock falls
                AISR_WRITE_ACK: begin
                    if (scl_fall) begin
                        state_d.sda_oe = 1'b0;
                        state_d.st = AISR_WRITE;
                    end
                end

                // spare codes cannot occur; fall back to a released idle
                default: begin
                    state_d.st = AISR_IDLE;
                    state_d.sda_oe = 1'b0;
                end
            endcase
        end

        // a new conversion leaves sleep; the held result stays until the next word replaces it
        if (start_conv) begin
            state_d.busy = 1'b1;
            state_d.conv_start = 1'b1;
        end
    end

    // reset leaves busy set and a start pulse out with the default setup
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= PORT_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // open drain: the output level is always low, only the enable moves
    assign sda_o = 1'b0;
    assign sda_oe = state_q.sda_oe;

    // status and setup come straight from registers
    assign conv_start = state_q.conv_start;
    assign converting = state_q.busy;
    assign cfg_o = state_q.cfg;
    assign bus_busy = state_q.bus_busy;
endmodule // aisr_port

`default_nettype wire

// ==== core/aisr_pkg.sv ====
// package: widths, encodings, states and state records of the adc i2c result port
package aisr_pkg;

    // link field widths
    localparam int ADDR_W = 7;
    localparam int BYTE_W = 8;
    localparam int CNT_W = 4;
    localparam int NBYTE_W = 3;
    localparam int WBYTE_W = 2;
    localparam int PRE_W = 3;
    localparam int RESULT_W = 32;
    localparam int CFG_W = 16;
    localparam int CODE_W = 24;
    localparam int SUB_W = 6;

    // bit counts and byte limits
    localparam logic [CNT_W-1:0] BYTE_LAST = 4'h8;
    localparam logic [NBYTE_W-1:0] RESULT_BYTES = 3'h4;
    localparam logic [WBYTE_W-1:0] CFG_BYTES = 2'h2;
    localparam logic RW_READ = 1'b1;

    // preamble and enable patterns at the head of the first configuration byte
    localparam logic [PRE_W-1:0] PRE_KEEP_A = 3'h0;
    localparam logic [PRE_W-1:0] PRE_KEEP_B = 3'h4;
    localparam logic [PRE_W-1:0] PRE_LOAD = 3'h5;

    // power-on setup: first pair differential, 50/60 Hz rejection, normal speed
    localparam logic [CFG_W-1:0] CFG_RESET = 16'ha000;

    // result word as shifted out, most significant field first
    typedef struct packed {
        logic sign;
        logic msb;
        logic [CODE_W-1:0] code;
        logic [SUB_W-1:0] sub;
    } aisr_result_s;

    // pins that arrive from outside the clock domain
    typedef struct packed {
        logic [ADDR_W-1:0] dev_addr;
        logic scl;
        logic sda;
    } aisr_pins_s;

    localparam aisr_pins_s PINS_IDLE = '{dev_addr: '0, scl: 1'b1, sda: 1'b1};

    typedef enum logic [2:0] {
        AISR_IDLE = 3'b000,
        AISR_ADDR = 3'b001,
        AISR_ADDR_ACK = 3'b010,
        AISR_READ = 3'b011,
        AISR_READ_ACK = 3'b100,
        AISR_WRITE = 3'b101,
        AISR_WRITE_ACK = 3'b110
    } aisr_state_e;

    typedef struct packed {
        aisr_state_e st;
        logic [CNT_W-1:0] cnt;
        logic [BYTE_W-1:0] shin;
        logic [RESULT_W-1:0] shout;
        logic rw;
        logic [NBYTE_W-1:0] nbytes;
        logic [WBYTE_W-1:0] wbytes;
        logic [PRE_W-1:0] pre;
        logic mack;
        logic wvalid;
        logic rd_active;
        logic sda_oe;
        logic bus_busy;
        logic busy;
        logic conv_start;
        aisr_result_s result;
        logic [CFG_W-1:0] cfg;
        logic scl_prev;
        logic sda_prev;
    } aisr_port_s;

    localparam aisr_port_s PORT_RESET = '{
        st: AISR_IDLE, cnt: '0, shin: '0, shout: '0, rw: 1'b0, nbytes: '0,
        wbytes: '0, pre: '0, mack: 1'b0, wvalid: 1'b0, rd_active: 1'b0,
        sda_oe: 1'b0, bus_busy: 1'b0, busy: 1'b1, conv_start: 1'b1,
        result: '0, cfg: CFG_RESET, scl_prev: 1'b1, sda_prev: 1'b1};

endpackage

// ==== core/aisr_sync.sv ====
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
`default_nettype none

module aisr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } aisr_sync_s;

    aisr_sync_s state_q;
    aisr_sync_s state_d;

    // meta stage feeds only the stable stage
    always_comb begin
        state_d.meta = async_i;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= '{meta: RESET_VAL, stable: RESET_VAL};
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_o = state_q.stable;
endmodule // aisr_sync

`default_nettype wire

// ==== core/aisr_fifo.sv ====
// result word fifo between the converter and the serial port
`timescale 1ns/10ps
`default_nettype none

module aisr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
    localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } aisr_fifo_s;

    aisr_fifo_s state_q;
    aisr_fifo_s state_d;
    logic push;
    logic pop;

    // pointers wrap at depth so any depth works, not only powers of two
    always_comb begin
        state_d = state_q;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (push) begin
            state_d.mem[state_q.wr] = in_data;
            state_d.wr = (state_q.wr == PTR_LAST) ? '0 : state_q.wr + 1'b1;
        end
        if (pop) begin
            state_d.rd = (state_q.rd == PTR_LAST) ? '0 : state_q.rd + 1'b1;
        end
        if (push && !pop) begin
            state_d.cnt = state_q.cnt + 1'b1;
        end else if (pop && !push) begin
            state_d.cnt = state_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign in_ready = (state_q.cnt != CNT_FULL);
    assign out_valid = (state_q.cnt != '0);
    assign out_data = state_q.mem[state_q.rd];
endmodule // aisr_fifo

`default_nettype wire

// ==== dv/aisr_port_asserts.sv ====
// checker: port-level assertions for the adc i2c result port
`timescale 1ns/10ps
`default_nettype none

module aisr_port_asserts
    import aisr_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic [ADDR_W-1:0] dev_addr,
    input wire aisr_result_s res_in,
    input wire logic res_in_valid,
    input wire logic res_in_ready,
    input wire logic conv_start,
    input wire logic converting,
    input wire logic [CFG_W-1:0] cfg_o,
    input wire logic bus_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // bus conditions on the raw pins; the port reacts after its synchroniser
    sequence s_start;
        scl_i && $fell(sda_i);
    endsequence
    sequence s_stop;
        scl_i && $rose(sda_i);
    endsequence

    property p_open_drain; sda_o == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data driven high");
    property p_idle_quiet; !bus_busy |-> !sda_oe; endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("drive on idle bus");
    property p_start_busy; s_start |-> ##[1:6] bus_busy; endproperty
    a_start_busy: assert property (p_start_busy) else $error("start missed");
    property p_stop_free; s_stop |-> ##[1:6] !bus_busy; endproperty
    a_stop_free: assert property (p_stop_free) else $error("stop missed");
    // the drive may only move while the link clock is low
    property p_scl_low; $changed(sda_oe) |-> !scl_i; endproperty
    a_scl_low: assert property (p_scl_low) else $error("drive moved, clock high");
    property p_nack_conv; $rose(sda_oe) |-> !$past(converting); endproperty
    a_nack_conv: assert property (p_nack_conv) else $error("ack while converting");
    // busy rises with the pulse; a queued word may end it the very next cycle
    property p_conv_go; conv_start |-> converting ##1 !conv_start; endproperty
    a_conv_go: assert property (p_conv_go) else $error("bad conversion start");
    // a conversion only starts from bus traffic, so a free bus keeps it asleep
    property p_sleep; !converting && !bus_busy |=> !converting; endproperty
    a_sleep: assert property (p_sleep) else $error("woke unaddressed");
    property p_cfg_xfer; $changed(cfg_o) |-> bus_busy; endproperty
    a_cfg_xfer: assert property (p_cfg_xfer) else $error("config moved off bus");
endmodule // aisr_port_asserts
`default_nettype wire

// ==== dv/aisr_master.sv ====
// partner model: i2c bus master making the link clock and data bits
`timescale 1ns/10ps
`default_nettype none

module aisr_master (
    input wire logic sda,
    output logic scl,
    output logic sda_oe
);
    // quarter of the 64 ns link period; nonblocking, so a change that lands
    // on a clock edge is taken by the port's sampler one edge later
    localparam time QTR = 16ns;

    // clock stands high and data released between frames
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    // start and repeated start are the same on the wire
    task automatic start();
        sda_oe <= 1'b0;
        #QTR scl <= 1'b1;
        #QTR sda_oe <= 1'b1;
        #QTR scl <= 1'b0;
        #QTR;
    endtask

    // data low before the clock rises, then released to the pull-up
    task automatic stop();
        sda_oe <= 1'b1;
        #QTR scl <= 1'b1;
        #QTR sda_oe <= 1'b0;
        #(2*QTR);
    endtask

    // eight bits msb first then the ninth; data moves only with clock low
    task automatic xbyte(input logic [7:0] tx, input logic a9, output logic [7:0] rx,
        output logic r9);
        for (int i = 8; i >= 0; i--) begin
            sda_oe <= (i > 0) ? !tx[i-1] : !a9;
            #QTR scl <= 1'b1;
            #QTR;
            if (i > 0) rx[i-1] = sda;
            else r9 = sda;
            #QTR scl <= 1'b0;
            #QTR;
        end
    endtask
endmodule // aisr_master
`default_nettype wire

// ==== dv/adc_i2c_slave_result_port_test.sv ====
// testbench: i2c master traffic and converter feed against the result port
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("FAIL %0t: got %h expected %h", $time, (got), (exp)); \
    end \
end

module adc_i2c_slave_result_port_test import aisr_pkg::*; ();
    localparam logic [ADDR_W-1:0] OWN_ADDR = 7'h29;
    localparam int LIMIT = 30000;
    logic clk, rst_n, res_in_valid, res_in_ready, sda_o, sda_oe;
    logic m_scl, m_oe, sda_w, conv_start, converting, bus_busy;
    logic [CFG_W-1:0] cfg_o;
    aisr_result_s res_in;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    // range ends, zero, minus one code and mixed sub bits
    logic [RESULT_W-1:0] words [9] = '{32'hc000_0000, 32'hbfff_ffc0, 32'ha000_0015,
        32'h8000_002a, 32'h7fff_ffff, 32'h6000_0000, 32'h4000_0000, 32'h3fff_ff80,
        32'h5a5a_a5a5};
    // keep (000), load (101), second byte only (100)
    logic [7:0] cfg_b1 [3] = '{8'h13, 8'hb3, 8'h9f};
    logic [7:0] cfg_b2 [3] = '{8'h77, 8'h5c, 8'h21};
    logic [CFG_W-1:0] cfg_exp [3] = '{16'ha000, 16'hb35c, 16'hb321};

    // open drain wire with pull-up
    assign sda_w = !(m_oe | sda_oe);

    aisr_port #(.FIFO_DEPTH(8)) i_aisr_port (.clk(clk), .rst_n(rst_n), .scl_i(m_scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .dev_addr(OWN_ADDR),
        .res_in(res_in), .res_in_valid(res_in_valid), .res_in_ready(res_in_ready),
        .conv_start(conv_start), .converting(converting), .cfg_o(cfg_o),
        .bus_busy(bus_busy));
    aisr_master i_aisr_master (.sda(sda_w), .scl(m_scl), .sda_oe(m_oe));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // a hang ends the run as a failure
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            $display("FAIL %0t: run timed out", $time);
            final_report();
        end
    end

    task automatic final_report();
        $display("checked %0d values, %0d mismatches", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // converter side: hold the word until the fifo takes it, then let it settle
    task automatic push(input logic [RESULT_W-1:0] w);
        @(posedge clk);
        res_in <= aisr_result_s'(w);
        res_in_valid <= 1'b1;
        do @(posedge clk); while (res_in_ready !== 1'b1);
        res_in_valid <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic addr(input logic [ADDR_W-1:0] a, input logic rw, input logic nack);
        logic [7:0] rx;
        logic r9;
        i_aisr_master.start();
        `CHK(bus_busy, 1'b1)
        i_aisr_master.xbyte({a, rw}, 1'b1, rx, r9);
        `CHK(r9, nack)
    endtask

    task automatic wbyte(input logic [7:0] b);
        logic [7:0] rx;
        logic r9;
        i_aisr_master.xbyte(b, 1'b1, rx, r9);
        `CHK(r9, 1'b0)
    endtask

    // read nb bytes msb first, acking all but the last
    task automatic read_word(input int nb, input logic [RESULT_W-1:0] w);
        logic [7:0] rx;
        logic r9;
        addr(OWN_ADDR, RW_READ, 1'b0);
        for (int i = 0; i < nb; i++) begin
            i_aisr_master.xbyte(8'hff, i == nb - 1, rx, r9);
            `CHK(rx, w[31-8*i -: 8])
        end
    endtask

    initial begin
        rst_n = 1'b0;
        res_in = '0;
        res_in_valid = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        `CHK(cfg_o, CFG_RESET)
        `CHK(converting, 1'b1)
        `CHK(sda_oe, 1'b0)
        $display("test reset done");
        addr(OWN_ADDR, RW_READ, 1'b1);
        i_aisr_master.stop();
        `CHK(bus_busy, 1'b0)
        $display("test busy_nack done");
        push(words[0]);
        `CHK(converting, 1'b0)
        addr(OWN_ADDR ^ 7'h01, RW_READ, 1'b1);
        i_aisr_master.stop();
        // asleep, so every word queues until the fifo refuses
        for (int k = 1; k < 9; k++) push(words[k]);
        `CHK(res_in_ready, 1'b0)
        $display("test fill done");
        for (int k = 0; k < 9; k++) begin
            read_word(4, words[k]);
            i_aisr_master.stop();
        end
        `CHK(converting, 1'b1)
        `CHK(res_in_ready, 1'b1)
        $display("test drain done");
        // write, repeated start, short read, stop
        for (int k = 0; k < 3; k++) begin
            push(words[k]);
            addr(OWN_ADDR, 1'b0, 1'b0);
            wbyte(cfg_b1[k]);
            wbyte(cfg_b2[k]);
            read_word(1, words[k]);
            i_aisr_master.stop();
            `CHK(cfg_o, cfg_exp[k])
            `CHK(converting, 1'b1)
        end
        $display("test config done");
        final_report();
    end
endmodule // adc_i2c_slave_result_port_test

bind aisr_port aisr_port_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) i_aisr_port_asserts (
    .clk(clk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .dev_addr(dev_addr), .res_in(res_in), .res_in_valid(res_in_valid),
    .res_in_ready(res_in_ready), .conv_start(conv_start), .converting(converting),
    .cfg_o(cfg_o), .bus_busy(bus_busy));
`default_nettype wire
